//--- hdl/wdog_defs.svh
/*
  Constants for the complement-retrigger watchdog: register address,
  field positions, reset values and the timeout unit.
  Assumes it is included by bare name from hdl/.
*/
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH

`define WD_ADDR_W 16
`define WD_DATA_W 8
`define WD_REG_ADDR 16'h0202
`define WD_CAUSE_BIT 0
`define WD_UNIT_CYCLES 65536
`define WD_UNIT_W 16
`define WD_PATTERN_RST 8'h00
`define WD_PERIOD_RST 8'h00
`define WD_CAUSE_IDLE 1'b1
`define WD_CAUSE_WDOG 1'b0
`define WD_READ_PAD 7'h00

`endif

//--- hdl/wdog_pkg.sv
/*
  Types shared by the watchdog files.
  Assumes wdog_defs.svh is available on the include path.
*/
`include "wdog_defs.svh"

package wdog_pkg;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_RUN,
    WD_FIRE
  } wd_state_e;

  typedef struct packed {
    logic [`WD_ADDR_W-1:0] addr;
    logic [`WD_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cpu_req_s;

endpackage

//--- hdl/wd_prescaler.sv
/*
  Timeout unit divider: one-cycle pulse every 65536 prescaled ticks.
  Assumes tick_i is the system clock enable after the CPU-speed prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"

module wd_prescaler #(
  parameter int unsigned UNIT_W = `WD_UNIT_W
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic clear_i, // Restart the unit
  input wire logic tick_i, // Prescaled clock enable
  output logic unit_o // Pulse at end of each unit
);

  logic [UNIT_W-1:0] cnt_reg;
  logic [UNIT_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (clear_i)
    begin
      cnt_next = '0;
    end
    else if (tick_i)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  assign unit_o = tick_i && !clear_i && (&cnt_reg);

endmodule

`default_nettype wire

//--- hdl/complement_retrigger_watchdog.sv
/*
  Complement-retrigger watchdog on the processor I/O page.
  Assumes a synchronous CPU bus with one-cycle read/write strobes, a
  prescaled system clock enable, and that the chip reset it raises is
  fed back into rst_n_i; ext_rst_n_i marks external (power-on) resets.
*/
// Behaviour
// R1 - After any reset the watchdog is idle and cannot fire.
// R2 - First write starts it; software cannot stop it afterwards.
// R3 - Retrigger only with inverted previous pattern; restarts period, new reference.
// R4 - Missing correct retrigger within period resets the chip at period end.
// R5 - Any wrong value written while running resets the chip.
// R6 - Timeout is (value plus one) times 65536 system clock periods.
// R7 - Counter runs from system clock after CPU-speed prescaler.
// R8 - Range about 16 ms to 4 s at 4 MHz, half at 8 MHz.
// R9 - Read bit 0 is zero if last reset came from the watchdog.
// R10 - Cause bit set back to one only by external reset, not by watchdog reset.
// R11 - Software should not program values below 2.
// R12 - Period and pattern are 8 bits wide.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"

module complement_retrigger_watchdog #(
  parameter int unsigned DATA_W = `WD_DATA_W
) (
  input wire logic ref_clk_i, // System clock, 10 MHz
  input wire logic rst_n_i, // Chip reset, synchronous, active low
  input wire logic ext_rst_n_i, // External reset, synchronous, active low
  input wire logic sys_tick_i, // Prescaled system clock enable
  input wire wdog_pkg::cpu_req_s cpu_req_i, // CPU access strobes
  output logic [DATA_W-1:0] rdata_o, // Registered read data
  output logic wd_reset_o, // Chip reset request, held until chip reset
  output logic running_o // Watchdog is armed
);

  wdog_pkg::wd_state_e state_reg;
  wdog_pkg::wd_state_e state_next;
  logic [DATA_W-1:0] pattern_reg;
  logic [DATA_W-1:0] pattern_next;
  logic [DATA_W-1:0] units_reg;
  logic [DATA_W-1:0] units_next;
  logic [DATA_W-1:0] period_reg;
  logic [DATA_W-1:0] period_next;
  logic cause_reg;
  logic cause_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic unit_done;
  logic sel;
  logic wr_hit;
  logic good_wr;
  logic restart;

  assign sel = (cpu_req_i.addr == `WD_REG_ADDR);
  assign wr_hit = sel && cpu_req_i.wr;
  assign good_wr = wr_hit && (cpu_req_i.wdata == ~pattern_reg); // R3
  assign restart = wr_hit && ((state_reg == wdog_pkg::WD_IDLE) || good_wr);

  wd_prescaler #(
    .UNIT_W(`WD_UNIT_W)
  ) u_unit (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(restart),
    .tick_i(sys_tick_i), // R7
    .unit_o(unit_done)
  );

  always_comb
  begin
    state_next = state_reg;
    pattern_next = pattern_reg;
    units_next = units_reg;
    period_next = period_reg;
    case (state_reg)
      wdog_pkg::WD_IDLE:
      begin
        if (wr_hit) // R2
        begin
          state_next = wdog_pkg::WD_RUN;
          pattern_next = cpu_req_i.wdata; // R12
          period_next = cpu_req_i.wdata; // R6
          units_next = '0;
        end
      end
      wdog_pkg::WD_RUN:
      begin
        if (good_wr) // R3
        begin
          pattern_next = cpu_req_i.wdata;
          units_next = '0;
        end
        else if (wr_hit) // R5
        begin
          state_next = wdog_pkg::WD_FIRE;
        end
        else if (unit_done)
        begin
          if (units_reg == period_reg) // R6
          begin
            state_next = wdog_pkg::WD_FIRE; // R4
          end
          else
          begin
            units_next = units_reg + 1'b1; // R8
          end
        end
      end
      default:
      begin
        state_next = wdog_pkg::WD_FIRE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= wdog_pkg::WD_IDLE; // R1
      pattern_reg <= `WD_PATTERN_RST;
      units_reg <= '0;
      period_reg <= `WD_PERIOD_RST;
    end
    else
    begin
      state_reg <= state_next;
      pattern_reg <= pattern_next;
      units_reg <= units_next;
      period_reg <= period_next;
    end
  end

  // Cause flag survives chip reset; only external reset restores it
  always_comb
  begin
    cause_next = cause_reg;
    if (state_reg == wdog_pkg::WD_FIRE)
    begin
      cause_next = `WD_CAUSE_WDOG;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!ext_rst_n_i)
    begin
      cause_reg <= `WD_CAUSE_IDLE; // R10
    end
    else
    begin
      cause_reg <= cause_next;
    end
  end

  always_comb
  begin
    rdata_next = rdata_reg;
    if (sel && cpu_req_i.rd)
    begin
      rdata_next = {`WD_READ_PAD, cause_reg}; // R9
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign wd_reset_o = (state_reg == wdog_pkg::WD_FIRE);
  assign running_o = (state_reg == wdog_pkg::WD_RUN);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_bad_write;
    running_o && wr_hit && !good_wr;
  endsequence

  a_idle_no_fire: assert property ( // R1
    $past(state_reg) == wdog_pkg::WD_IDLE && !$past(wr_hit) |-> !wd_reset_o)
    else $error("watchdog fired while idle");
  a_first_write_arms: assert property ( // R2
    state_reg == wdog_pkg::WD_IDLE && wr_hit |=> running_o)
    else $error("first write did not arm");
  a_never_stops: assert property ( // R2
    running_o |=> running_o || wd_reset_o)
    else $error("watchdog stopped without reset");
  a_good_retrigger: assert property ( // R3
    running_o && good_wr |=> running_o && units_reg == '0
      && pattern_reg == $past(cpu_req_i.wdata))
    else $error("retrigger not taken");
  a_bad_write_fires: assert property ( // R5
    s_bad_write |=> wd_reset_o)
    else $error("wrong pattern did not reset");
  a_timeout_fires: assert property ( // R4
    running_o && unit_done && !wr_hit && units_reg == period_reg |=> wd_reset_o)
    else $error("timeout did not reset");
  a_no_early_fire: assert property ( // R6
    running_o && !wr_hit && units_reg != period_reg |=> !wd_reset_o)
    else $error("reset before period end");
  a_cause_marked: assert property ( // R9
    wd_reset_o |=> cause_reg == `WD_CAUSE_WDOG)
    else $error("cause bit not set");
  a_read_cause: assert property ( // R9
    sel && cpu_req_i.rd |=> rdata_o == {`WD_READ_PAD, $past(cause_reg)})
    else $error("read data wrong");
  a_period_armed: assert property ( // R6
    state_reg == wdog_pkg::WD_IDLE && wr_hit |=> period_reg == $past(cpu_req_i.wdata))
    else $error("period not captured");
  a_period_kept: assert property ( // R3
    running_o && good_wr |=> period_reg == $past(period_reg))
    else $error("period changed by retrigger");
  a_fire_holds: assert property ( // R4
    wd_reset_o |=> wd_reset_o)
    else $error("chip reset request dropped");

endmodule

`default_nettype wire

//--- sim/test_complement_retrigger_watchdog.sv
/*
  Bench for the watchdog: register access, arming, retrigger, faults.
  Assumes the hdl/ files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.svh"

module test_complement_retrigger_watchdog;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ext_rst_n_i = 1'b0;
  logic sys_tick_i = 1'b1;
  wdog_pkg::cpu_req_s cpu_req_i = '0;
  logic [7:0] rdata_o;
  logic wd_reset_o;
  logic running_o;
  int errors = 0;
  int cmp_count = 0;
  int n;

  complement_retrigger_watchdog dut_u (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ext_rst_n_i(ext_rst_n_i),
    .sys_tick_i(sys_tick_i),
    .cpu_req_i(cpu_req_i),
    .rdata_o(rdata_o),
    .wd_reset_o(wd_reset_o),
    .running_o(running_o)
  );

  initial
  begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  // One-cycle strobe, then one idle cycle so results have landed
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    cpu_req_i.addr = a;
    cpu_req_i.wdata = d;
    cpu_req_i.wr = w;
    cpu_req_i.rd = ~w;
    cyc(1);
    cpu_req_i = '0;
    cyc(1);
  endtask

  task automatic rst(input logic ext);
    rst_n_i = 1'b0;
    ext_rst_n_i = ~ext;
    cyc(16);
    rst_n_i = 1'b1;
    ext_rst_n_i = 1'b1;
    cyc(1);
  endtask

  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    rst(1'b1);
    chk1("running", 1'b0, running_o);
    acc(16'h0203, 8'h00, 1'b1);
    chk1("running", 1'b0, running_o);
    acc(`WD_REG_ADDR, 8'h00, 1'b0);
    chk8("cause", 8'h01, rdata_o);
    $display("test idle done");
    // Repeating the same value instead of its complement
    acc(`WD_REG_ADDR, 8'h5a, 1'b1);
    chk1("running", 1'b1, running_o);
    chk1("wd_reset", 1'b0, wd_reset_o);
    acc(`WD_REG_ADDR, 8'h5a, 1'b1);
    chk1("wd_reset", 1'b1, wd_reset_o);
    rst(1'b0);
    chk1("running", 1'b0, running_o);
    acc(`WD_REG_ADDR, 8'h00, 1'b0);
    chk8("cause", 8'h00, rdata_o);
    rst(1'b1);
    acc(16'h0203, 8'h00, 1'b0);
    chk8("rdata", 8'h00, rdata_o);
    acc(`WD_REG_ADDR, 8'h00, 1'b0);
    chk8("cause", 8'h01, rdata_o);
    $display("test wrong value done");
    // Period 00 keeps the run short; retriggers must not change the period
    acc(`WD_REG_ADDR, 8'h00, 1'b1);
    cyc(100);
    acc(`WD_REG_ADDR, 8'hff, 1'b1);
    acc(`WD_REG_ADDR, 8'h00, 1'b1);
    acc(`WD_REG_ADDR, 8'hff, 1'b1);
    chk1("wd_reset", 1'b0, wd_reset_o);
    chk1("running", 1'b1, running_o);
    sys_tick_i = 1'b0;
    cyc(100);
    chk1("wd_reset", 1'b0, wd_reset_o);
    sys_tick_i = 1'b1;
    n = 100;
    while (wd_reset_o !== 1'b1 && n < 70000)
    begin
      cyc(1);
      n++;
    end
    if (n >= 70000)
    begin
      errors++;
    end
    else
    begin
      chk1("timeout", 1'b1, n >= 65634 && n <= 65638);
      rst(1'b0);
      acc(`WD_REG_ADDR, 8'h00, 1'b0);
      chk8("cause", 8'h00, rdata_o);
    end
    $display("test timeout done");
    complete_run();
  end
endmodule

`default_nettype wire
